/* File: accum_transfer_instr_exec.sv */
// Executes the pair, index, table-read and comparator-write transfers.
// Assumes a one-hot instruction pulse; requests met while busy are refused; program memory
// answers one clock after its address.
//
// Notes on behaviour
// - Pair transfer puts pair high nibble into B, low nibble into accumulator.
// - Table read is one word yet takes three instruction cycles.
// - Table read pushes PC, fetches, restores PC, pops; one stack level used.
// - Table address is page, then index bits, then accumulator bits.
// - Fetched word bits 7-4 go to B, bits 3-0 to accumulator.
// - Index transfer fills accumulator bits 2-0, clears bit 3.
// - Comparator write does nothing while in conversion mode.
// - In comparator mode, B goes to comparator high nibble, accumulator low.
// - Mode bit is bit 3 of converter control register one.
`timescale 1ns/1ps
module accum_transfer_instr_exec #(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic                                 ref_clk,     // 50 MHz clock
  input  wire logic                                 srst,        // Sync reset
  input  wire xfer_pkg::instr_type                  instr,       // Instruction pulse
  input  wire logic [xfer_pkg::PAGE_W-1:0]          page,        // Table page operand
  input  wire logic [xfer_pkg::PAIR_W-1:0]          pair_reg,    // Pair register
  input  wire logic [xfer_pkg::INDEX_W-1:0]         index_reg,   // Index register
  input  wire logic [xfer_pkg::CTRL_W-1:0]          converter_control_one, // Ctrl reg 1
  input  wire logic [xfer_pkg::PC_W-1:0]            pc_in,       // Current PC
  input  wire logic [xfer_pkg::ROMW_W-1:0]          rom_data,    // Program word
  output xfer_pkg::regs_type                        regs,        // A, B, carry
  output logic [xfer_pkg::PAIR_W-1:0]               comparator,  // Comparator reg
  output logic [xfer_pkg::PC_W-1:0]                 rom_addr,    // Program address
  output logic [xfer_pkg::PC_W-1:0]                 pc_restore,  // Restored PC
  output logic                                      pc_load,     // PC restore pulse
  output logic [xfer_pkg::STACK_PTR_W-1:0]          stack_pointer, // Stack pointer
  output logic                                      busy         // Table read busy
);

  // ----------------------------------------------------------------
  // Table-read sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, FETCH, LOAD} tbl_state_type;
  tbl_state_type state;
  logic [xfer_pkg::PC_W-1:0] saved_pc;
  logic                      converter_mode_select;

  assign converter_mode_select = converter_control_one[xfer_pkg::MODE_BIT];
  assign busy = (state != IDLE);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state <= IDLE;
    else
      case (state)
        IDLE:    if (instr.program_table_read) state <= FETCH;
        FETCH:   state <= LOAD;
        LOAD:    state <= IDLE;
        default: state <= IDLE;
      endcase
  end

  // Push and pop happen as the table read enters and leaves
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      stack_pointer <= '0;
    else if (state == IDLE && instr.program_table_read)
      stack_pointer <= stack_pointer + xfer_pkg::STACK_STEP;
    else if (state == LOAD)
      stack_pointer <= stack_pointer - xfer_pkg::STACK_STEP;
  end

  return_stack_mem #(
    .DEPTH (STACK_DEPTH),
    .AW    (xfer_pkg::STACK_PTR_W),
    .W     (xfer_pkg::PC_W)
  ) u_return_stack (
    .ref_clk (ref_clk),
    .we      (state == IDLE && instr.program_table_read),
    .waddr   (stack_pointer + xfer_pkg::STACK_STEP),
    .wdata   (pc_in),
    .raddr   (stack_pointer),
    .rdata   (saved_pc)
  );

  // Address is held in a register so the ROM sees it stable for the fetch
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rom_addr <= xfer_pkg::PC_ZERO;
    else if (state == IDLE && instr.program_table_read)
      rom_addr <= {page, index_reg, regs.acc};
  end

  // Restore comes from the stack stage, not from a shadow copy
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pc_restore <= xfer_pkg::PC_ZERO;
      pc_load    <= 1'b0;
    end
    else
    begin
      pc_load <= (state == LOAD);
      if (state == LOAD)
        pc_restore <= saved_pc;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and register B
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      regs.acc   <= xfer_pkg::NIB_ZERO;
      regs.reg_b <= xfer_pkg::NIB_ZERO;
    end
    else if (state == LOAD)
    begin
      regs.reg_b <= rom_data[xfer_pkg::HI_NIB_LSB +: xfer_pkg::NIB_W];
      regs.acc   <= rom_data[0 +: xfer_pkg::NIB_W];
    end
    else if (state == IDLE && instr.pair_to_acc_b_transfer)
    begin
      regs.reg_b <= pair_reg[xfer_pkg::HI_NIB_LSB +: xfer_pkg::NIB_W];
      regs.acc   <= pair_reg[0 +: xfer_pkg::NIB_W];
    end
    else if (state == IDLE && instr.index_to_acc_transfer)
      regs.acc <= {1'b0, index_reg};
  end

  // Carry is owned elsewhere; these transfers only hold it
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      regs.carry <= 1'b0;
    else
      regs.carry <= regs.carry;
  end

  // ----------------------------------------------------------------
  // Comparator register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      comparator <= xfer_pkg::BYTE_ZERO;
    else if (state == IDLE && instr.acc_b_to_comparator_write
             && converter_mode_select == xfer_pkg::MODE_CMP)
      comparator <= {regs.reg_b, regs.acc};
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_table_three_cycles: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && instr.program_table_read) |=> busy ##1 busy ##1 !busy)
    else $error("table read not three cycles");
  chk_stack_balanced: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && instr.program_table_read) |-> ##3 stack_pointer == $past(stack_pointer, 3))
    else $error("stack pointer not restored");
  chk_pc_restored: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && instr.program_table_read) |-> ##3 pc_load && pc_restore == $past(pc_in, 3))
    else $error("program counter not restored");
  chk_table_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && instr.program_table_read) |=> rom_addr == {$past(page), $past(index_reg),
      $past(regs.acc)})
    else $error("table address wrong");
  chk_table_load: assert property (@(posedge ref_clk) disable iff (srst)
    (state == LOAD) |=> regs.reg_b == $past(rom_data[7:4]) && regs.acc == $past(rom_data[3:0]))
    else $error("table data load wrong");
  chk_pair_split: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && instr.pair_to_acc_b_transfer) |=> regs.reg_b == $past(pair_reg[7:4])
      && regs.acc == $past(pair_reg[3:0]))
    else $error("pair transfer wrong");
  chk_index_fill: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && instr.index_to_acc_transfer && !instr.pair_to_acc_b_transfer)
      |=> regs.acc == {1'b0, $past(index_reg)})
    else $error("index transfer wrong");
  chk_cmp_nop: assert property (@(posedge ref_clk) disable iff (srst)
    (instr.acc_b_to_comparator_write && !converter_control_one[3]) |=> $stable(comparator))
    else $error("comparator written in conversion mode");
  chk_cmp_write: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && instr.acc_b_to_comparator_write && converter_control_one[3])
      |=> comparator == {$past(regs.reg_b), $past(regs.acc)})
    else $error("comparator write wrong");
  chk_carry_kept: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && (instr.pair_to_acc_b_transfer || instr.index_to_acc_transfer))
      |=> $stable(regs.carry) && !busy)
    else $error("carry changed or stall");

  // ----------------------------------------------------------------
  // Refusal while busy, single-cycle comparator write, restore pulse and reset
  // ----------------------------------------------------------------
  chk_busy_refused: assert property (@(posedge ref_clk) disable iff (srst)
    (state == FETCH && (instr.pair_to_acc_b_transfer || instr.index_to_acc_transfer))
      |=> $stable(regs.acc) && $stable(regs.reg_b))
    else $error("transfer taken while busy");
  chk_cmp_busy: assert property (@(posedge ref_clk) disable iff (srst)
    (busy && instr.acc_b_to_comparator_write) |=> $stable(comparator))
    else $error("comparator written while busy");
  chk_cmp_single: assert property (@(posedge ref_clk) disable iff (srst)
    (state == IDLE && instr.acc_b_to_comparator_write) |=> !busy && $stable(regs.carry))
    else $error("comparator write stalled or moved carry");
  chk_restore_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    pc_load |=> !pc_load)
    else $error("restore pulse longer than one cycle");
  chk_reset_clear: assert property (@(posedge ref_clk)
    srst |=> stack_pointer == '0 && !busy && !pc_load)
    else $error("reset left a table read running");

  cov_table_read: cover property (@(posedge ref_clk) state == LOAD);
  cov_cmp_write:  cover property (@(posedge ref_clk)
    instr.acc_b_to_comparator_write && converter_control_one[3]);
  cov_cmp_nop:    cover property (@(posedge ref_clk)
    instr.acc_b_to_comparator_write && !converter_control_one[3]);
  cov_pair:       cover property (@(posedge ref_clk) instr.pair_to_acc_b_transfer);
  cov_refused:    cover property (@(posedge ref_clk)
    state == FETCH && instr.pair_to_acc_b_transfer);

endmodule : accum_transfer_instr_exec

/* File: xfer_pkg.sv */
// Package for the accumulator transfer instruction executor.
// Assumes one instruction clock domain; decoding of opcodes happens upstream.
package xfer_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NIB_W    = 4;
  localparam int PAIR_W   = 8;
  localparam int INDEX_W  = 3;
  localparam int PAGE_W   = 5;
  localparam int PC_LOW_W    = 7;
  localparam int PC_W        = PAGE_W + PC_LOW_W;
  localparam int ROMW_W      = 10;
  localparam int STACK_PTR_W = 3;
  localparam int CTRL_W   = 4;

  // ----------------------------------------------------------------
  // Field positions and constants
  // ----------------------------------------------------------------
  localparam int MODE_BIT     = 3;
  localparam int HI_NIB_LSB   = 4;
  localparam int TABLE_CYCLES = 3;
  localparam logic [STACK_PTR_W-1:0] STACK_STEP = 3'h1;
  localparam logic [NIB_W-1:0]   NIB_ZERO = 4'h0;
  localparam logic [PC_W-1:0]    PC_ZERO  = 12'h000;
  localparam logic [PAIR_W-1:0]  BYTE_ZERO = 8'h00;
  localparam logic               MODE_CMP = 1'b1;

  // One-hot instruction requests from the decoder
  typedef struct packed {
    logic pair_to_acc_b_transfer;
    logic program_table_read;
    logic index_to_acc_transfer;
    logic acc_b_to_comparator_write;
  } instr_type;

  // Architectural state visible to the rest of the CPU
  typedef struct packed {
    logic [NIB_W-1:0]  acc;
    logic [NIB_W-1:0]  reg_b;
    logic              carry;
  } regs_type;

endpackage : xfer_pkg

/* File: return_stack_mem.sv */
// Small stack memory holding saved program counters.
// Assumes one writer and one reader per clock; read data registered.
`timescale 1ns/1ps
module return_stack_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int W     = 12
) (
  input  wire logic          ref_clk,  // Instruction clock
  input  wire logic          we,       // Write strobe
  input  wire logic [AW-1:0] waddr,    // Write stage
  input  wire logic [W-1:0]  wdata,    // Value saved
  input  wire logic [AW-1:0] raddr,    // Read stage
  output logic      [W-1:0]  rdata     // Registered read data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    rdata <= mem[raddr];
  end
endmodule : return_stack_mem

/* File: accum_transfer_instr_exec_tb.sv */
// Self-checking bench for the accumulator transfer instruction executor.
// Assumes the design asserts its own rules internally; this bench drives ports only.
`timescale 1ns/1ps
module accum_transfer_instr_exec_tb;
  localparam logic [3:0] I_PAIR = 4'h8;
  localparam logic [3:0] I_TAB  = 4'h4;
  localparam logic [3:0] I_IDX  = 4'h2;
  localparam logic [3:0] I_CMP  = 4'h1;

  logic                                 ref_clk;
  logic                                 srst;
  xfer_pkg::instr_type                  instr;
  logic [xfer_pkg::PAGE_W-1:0]          page;
  logic [xfer_pkg::PAIR_W-1:0]          pair_reg;
  logic [xfer_pkg::INDEX_W-1:0]         index_reg;
  logic [xfer_pkg::CTRL_W-1:0]          converter_control_one;
  logic [xfer_pkg::PC_W-1:0]            pc_in;
  logic [xfer_pkg::ROMW_W-1:0]          rom_data;
  xfer_pkg::regs_type                   regs;
  logic [xfer_pkg::PAIR_W-1:0]          comparator;
  logic [xfer_pkg::PC_W-1:0]            rom_addr;
  logic [xfer_pkg::PC_W-1:0]            pc_restore;
  logic                                 pc_load;
  logic [xfer_pkg::STACK_PTR_W-1:0]     stack_pointer;
  logic                                 busy;
  int                                   n_mismatch;
  int                                   comparisons;

  accum_transfer_instr_exec dut_u (.ref_clk(ref_clk), .srst(srst), .instr(instr), .page(page),
    .pair_reg(pair_reg), .index_reg(index_reg), .converter_control_one(converter_control_one),
    .pc_in(pc_in), .rom_data(rom_data), .regs(regs), .comparator(comparator),
    .rom_addr(rom_addr), .pc_restore(pc_restore), .pc_load(pc_load),
    .stack_pointer(stack_pointer), .busy(busy));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Expected carry is always clear: the transfers never own it
  task automatic chk_regs(input logic [3:0] a, input logic [3:0] b, input string what);
    chk({3'h0, regs}, {3'h0, a, b, 1'b0}, what);
  endtask : chk_regs

  // One-cycle pulse; levels change at the same edge so they qualify it
  task automatic issue(input logic [3:0] code, input logic [7:0] pr, input logic [2:0] ix,
                       input logic [3:0] ctl);
    @(posedge ref_clk);
    instr                 <= xfer_pkg::instr_type'(code);
    pair_reg              <= pr;
    index_reg             <= ix;
    converter_control_one <= ctl;
    @(posedge ref_clk);
    instr                 <= xfer_pkg::instr_type'(4'h0);
    #1;
  endtask : issue

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_scn;
    chk_regs(4'h0, 4'h0, "reset regs");
    chk({4'h0, comparator}, 12'h000, "reset comparator");
    chk({9'h000, stack_pointer}, 12'h000, "reset stack pointer");
    chk({11'h000, busy}, 12'h000, "reset busy");
    chk({11'h000, pc_load}, 12'h000, "reset restore pulse");
    chk(rom_addr, 12'h000, "reset table address");
    chk(pc_restore, 12'h000, "reset restored counter");
  endtask : reset_scn

  task automatic pair_index_scn;
    issue(I_PAIR, 8'ha5, 3'h0, 4'h0);
    chk_regs(4'h5, 4'ha, "pair transfer");
    issue(I_PAIR, 8'h3f, 3'h0, 4'h0);
    issue(I_IDX, 8'h3f, 3'h7, 4'h0);
    chk_regs(4'h7, 4'h3, "index transfer");
  endtask : pair_index_scn

  task automatic comparator_scn;
    // Other control bits set high for the conversion-mode write, low for the comparator-mode write, so only the mode bit can matter
    issue(I_CMP, 8'h3f, 3'h7, 4'h7);
    chk({4'h0, comparator}, 12'h000, "write in conversion mode");
    issue(I_CMP, 8'h3f, 3'h7, 4'h8);
    chk({4'h0, comparator}, 12'h037, "write in comparator mode");
    chk_regs(4'h7, 4'h3, "regs after comparator write");
    chk({11'h000, busy}, 12'h000, "comparator write takes one cycle");
  endtask : comparator_scn

  task automatic table_scn;
    // New accumulator so a wrongly taken comparator write would show
    issue(I_IDX, 8'h3f, 3'h5, 4'h8);
    chk_regs(4'h5, 4'h3, "index before table read");
    @(posedge ref_clk);
    page     <= 5'h13; // page operand kept within the existing pages
    pc_in    <= 12'h9ab;
    rom_data <= 10'h2c6;
    instr    <= xfer_pkg::instr_type'(I_TAB);
    @(posedge ref_clk);
    // Taken here; the next two requests meet the fetch and load cycles
    instr    <= xfer_pkg::instr_type'(I_PAIR);
    pair_reg <= 8'he1;
    #1;
    chk({11'h000, busy}, 12'h001, "busy in fetch");
    chk(rom_addr, {5'h13, 3'h5, 4'h5}, "table address");
    chk({9'h000, stack_pointer}, 12'h001, "stack pushed");
    @(posedge ref_clk);
    instr <= xfer_pkg::instr_type'(I_CMP);
    #1;
    chk({11'h000, busy}, 12'h001, "busy in load");
    chk_regs(4'h5, 4'h3, "pair refused while busy");
    @(posedge ref_clk);
    instr <= xfer_pkg::instr_type'(4'h0);
    #1;
    chk({11'h000, busy}, 12'h000, "busy released after three cycles");
    chk({4'h0, comparator}, 12'h037, "comparator write refused while busy");
    chk_regs(4'h6, 4'hc, "table data loaded");
    chk({9'h000, stack_pointer}, 12'h000, "stack popped");
    chk({11'h000, pc_load}, 12'h001, "restore pulse");
    chk(pc_restore, 12'h9ab, "restored counter");
    @(posedge ref_clk);
    #1;
    chk({11'h000, pc_load}, 12'h000, "restore pulse ends");
  endtask : table_scn

  // Reset lands in the fetch cycle of a table read
  task automatic reset_mid_scn;
    @(posedge ref_clk);
    instr <= xfer_pkg::instr_type'(I_TAB);
    @(posedge ref_clk);
    instr <= xfer_pkg::instr_type'(4'h0);
    srst  <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk({11'h000, busy}, 12'h000, "reset ends table read");
    chk({9'h000, stack_pointer}, 12'h000, "reset clears stack pointer");
    chk_regs(4'h0, 4'h0, "reset clears regs");
    chk({4'h0, comparator}, 12'h000, "reset clears comparator");
    issue(I_IDX, 8'h00, 3'h2, 4'h0);
    chk_regs(4'h2, 4'h0, "first transfer after reset");
  endtask : reset_mid_scn

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    srst                  = 1'b1;
    instr                 = xfer_pkg::instr_type'(4'h0);
    page                  = 5'h00;
    pair_reg              = 8'h00;
    index_reg             = 3'h0;
    converter_control_one = 4'h0;
    pc_in                 = 12'h000;
    rom_data              = 10'h000;
    n_mismatch            = 0;
    comparisons           = 0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    reset_scn();
    pair_index_scn();
    comparator_scn();
    table_scn();
    reset_mid_scn();
    wrap_up();
  end

  // Hang guard: the sequence needs well under this many cycles
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    $display("[FAIL] %0t: run did not finish in time", $time);
    wrap_up();
  end
endmodule : accum_transfer_instr_exec_tb
